// ### common/radio_power_defines.svh
// Offsets, field positions, reset values and timing counts for the power-down and wake controller.
// Assumes a 200 MHz system clock and an 8-bit byte-wide register port.
`ifndef RADIO_POWER_DEFINES_SVH
`define RADIO_POWER_DEFINES_SVH
`define OFS_RX_WAKE_SOURCES     7'h45
`define OFS_RX_SLEEP_LOW        7'h46
`define OFS_RX_SLEEP_HIGH       7'h47
`define OFS_RX_WAKE_COUNT       7'h48
`define OFS_RX_UPDATE           7'h4B
`define OFS_RX_WAKE_EXT         7'h4C
`define OFS_TX_WAKE_EXT         7'h4D
`define OFS_TX_SLEEP_LOW        7'h57
`define OFS_TX_SLEEP_HIGH       7'h58
`define OFS_TX_WAKE_COUNT       7'h59
`define OFS_RX_MODE             7'h6A
`define OFS_TX_MODE             7'h6B
`define OFS_INT_CONFIG          7'h53
`define OFS_INT_FLAGS           7'h02
`define BIT_RX_POWER_DOWN       7
`define BIT_TX_POWER_DOWN       6
`define BIT_TX_PIN_WAKE         5
`define BIT_WAKE_ON_TIMER       4
`define BIT_INT_POLARITY        7
`define BIT_INT_WAKE_ENABLE     1
`define BIT_INT_WAKE_FLAG       1
`define UPDATE_IDLE_OK          8'h00
`define UPDATE_BUSY             8'h01
`define UPDATE_FAILED           8'h02
`define REG_RESET               8'h00
`define TICK_PERIOD_US          10000
`define CLK_PERIOD_NS           5
`define TICK_CYCLES             ((`TICK_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`define PULSE_MIN_US            1000
`define PULSE_CYCLES            ((`PULSE_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### common/radio_power_pkg.sv
// Types shared by the power-down and wake controller.
// Assumes nothing beyond the defines header.
package radio_power_pkg;
  // Power sequencing phases, binary coded.
  typedef enum logic [1:0] {
    PH_AWAKE  = 2'b00,
    PH_SEARCH = 2'b01,
    PH_ASLEEP = 2'b10,
    PH_RELINK = 2'b11
  } power_phase_t;
  // Register port request, one byte wide.
  typedef struct packed {
    logic       wrEn;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// ### hdl/radio_power_down_wake_control.sv
// Power-down and wake sequencing for one end of a paired wireless audio link.
// Assumes a byte register port from the serial slave, a link status from the radio,
// and a transfer-done answer from the control channel; wake pins are asynchronous.
// Notes on behaviour
// - No power-down entry while wake count zero.
// - Receiver sleeps once settings transfer succeeds.
// - Link loss: search sleep-count ticks, then sleep.
// - Automatic power down needs nonzero wake count.
// - Enabled pin level change ends power down.
// - Transmitter pin wake needs mode bit 5.
// - Receiver wake bits 0-3 enable input pins.
// - Timer wake bit 4 overrides pin wake.
// - After wake, sleep again if bit set.
// - Pin/link wake lasts (ext+1) times wake count.
// - Wake pulses shorter than 1 ms ignored.
// - Timer mode cycles sleep count, wake count.
// - Timer sleep overrides relink attempts.
// - Zero wake count: transmitter never resleeps.
// - Receiver sleep count: search length, and sleep length only with timer wake.
// - After auto sleep, configured wake mode applies.
// - Wake interrupt tracks sleep, no clearing.
// - Active-low pin low while awake or seeking.
// - Extended wake expiry resleeps despite cleared bit.
// - Linked and bit cleared: stay awake.
// - Update register reads 1 busy, 0 ok, 2 failed.
`timescale 1ns/1ps
`include "radio_power_defines.svh"
module radio_power_down_wake_control
  import radio_power_pkg::*;
#(
  parameter bit          IS_RECEIVER = 1'b0,        // Selects receiver or transmitter end.
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES, // Cycles per 10 ms tick.
  parameter int unsigned PULSE_CYCLES = `PULSE_CYCLES // Cycles a pin level must hold.
) (
  input  wire logic       sys_clk,        // System clock, 200 MHz.
  input  wire logic       rst,            // Asynchronous reset, active high.
  input  wire reg_req_t   regReq,         // Register write request.
  input  wire logic [6:0] regRdAddr,      // Register read address.
  output logic [7:0]      regRdData,      // Register read data.
  input  wire logic       linkUp,         // Radio link established.
  input  wire logic       transferDone,   // Receiver settings transfer finished, pulse.
  input  wire logic       transferOk,     // Transfer outcome with transferDone.
  output logic            transferStart,  // Request a receiver settings transfer, pulse.
  input  wire logic [3:0] generalInputPins,     // Receiver wake pins, asynchronous.
  input  wire logic       dedicatedInputPinOne, // Transmitter wake pin, asynchronous.
  output logic            powerDown,      // Radio and core powered down.
  output logic            irqOut          // Interrupt pin level.
);
  // Counts below two leave the divider and filter compares with no settled cycle.
  if (TICK_CYCLES < 2 || PULSE_CYCLES < 2) begin : g_bad_counts
    $error("Tick and pulse counts must be at least two cycles.");
  end
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] wakeSrcReg;     // Receiver wake sources.
  logic [15:0] sleepCountReg; // Sleep interval in ticks.
  logic [7:0] wakeCountReg;   // Wake interval in ticks.
  logic [7:0] wakeExtReg;     // Wake extension factor minus one.
  logic [7:0] modeReg;        // Own mode register.
  logic [7:0] intCfgReg;      // Interrupt configuration.
  logic [7:0] updateReg;      // Receiver update status.
  logic       pdBit;
  // Both ends share one map; each decodes its own half plus the shared wake-source, interrupt and update offsets.
  logic [6:0] ownSleepLo;
  logic [6:0] ownSleepHi;
  logic [6:0] ownWakeOfs;
  logic [6:0] ownExtOfs;
  logic [6:0] ownModeOfs;
  assign ownSleepLo = IS_RECEIVER ? `OFS_RX_SLEEP_LOW : `OFS_TX_SLEEP_LOW;
  assign ownSleepHi = IS_RECEIVER ? `OFS_RX_SLEEP_HIGH : `OFS_TX_SLEEP_HIGH;
  assign ownWakeOfs = IS_RECEIVER ? `OFS_RX_WAKE_COUNT : `OFS_TX_WAKE_COUNT;
  assign ownExtOfs  = IS_RECEIVER ? `OFS_RX_WAKE_EXT : `OFS_TX_WAKE_EXT;
  assign ownModeOfs = IS_RECEIVER ? `OFS_RX_MODE : `OFS_TX_MODE;
  assign pdBit = IS_RECEIVER
    ? modeReg[`BIT_RX_POWER_DOWN]
    : modeReg[`BIT_TX_POWER_DOWN];
  // Matches a write to a given offset.
  function automatic logic hit(input reg_req_t r, input logic [6:0] ofs);
    hit = r.wrEn && (r.addr == ofs);
  endfunction
  // Configuration writes; each register holds its value until rewritten.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wakeSrcReg <= `REG_RESET;
      sleepCountReg <= {`REG_RESET, `REG_RESET};
      wakeCountReg <= `REG_RESET;
      wakeExtReg <= `REG_RESET;
      modeReg <= `REG_RESET;
      intCfgReg <= `REG_RESET;
    end else begin
      if (hit(regReq, `OFS_RX_WAKE_SOURCES)) begin
        wakeSrcReg <= {3'h0, regReq.wdata[4:0]};
      end
      if (hit(regReq, ownSleepLo)) begin
        sleepCountReg[7:0] <= regReq.wdata;
      end
      if (hit(regReq, ownSleepHi)) begin
        sleepCountReg[15:8] <= regReq.wdata;
      end
      if (hit(regReq, ownWakeOfs)) begin
        wakeCountReg <= regReq.wdata;
      end
      if (hit(regReq, ownExtOfs)) begin
        wakeExtReg <= regReq.wdata;
      end
      if (hit(regReq, ownModeOfs)) begin
        modeReg <= regReq.wdata;
      end
      if (hit(regReq, `OFS_INT_CONFIG)) begin
        intCfgReg <= regReq.wdata;
      end
    end
  end
  // ------------------------------------------------------------
  // Receiver update register
  // ------------------------------------------------------------
  // Busy while a transfer runs; the outcome wins over a same-cycle write.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      updateReg <= `UPDATE_IDLE_OK;
      transferStart <= 1'b0;
    end else begin
      transferStart <= 1'b0;
      if (updateReg == `UPDATE_BUSY && transferDone) begin
        updateReg <= transferOk ? `UPDATE_IDLE_OK : `UPDATE_FAILED;
      end else if (hit(regReq, `OFS_RX_UPDATE) && regReq.wdata == `UPDATE_BUSY
                   && updateReg != `UPDATE_BUSY) begin
        updateReg <= `UPDATE_BUSY;
        transferStart <= 1'b1;
      end
    end
  end
  logic rxSettingsApplied; // Receiver end: settings arrived, sleep may start.
  assign rxSettingsApplied = transferDone && transferOk;
  // ------------------------------------------------------------
  // Tick prescaler
  // ------------------------------------------------------------
  logic [31:0] preCnt;
  logic        tick; // One-cycle pulse every 10 ms.
  // Free-running divider; the phase counter moves only on tick, the pin filter counters every cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      preCnt <= 32'h0;
      tick <= 1'b0;
    end else if (preCnt == TICK_CYCLES - 1) begin
      preCnt <= 32'h0;
      tick <= 1'b1;
    end else begin
      preCnt <= preCnt + 32'h1;
      tick <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // Wake pin synchronise and filter
  // ------------------------------------------------------------
  logic [4:0] pinMeta;
  logic [4:0] pinSync;
  logic [4:0] pinStable;    // Filtered level.
  logic [4:0] pinCand;
  logic [31:0] pinCnt [5];
  logic [4:0] pinChanged;   // One-cycle pulse per accepted level change.
  // Two flops first; only the second one is read by the filter.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinMeta <= 5'h0;
      pinSync <= 5'h0;
    end else begin
      pinMeta <= {dedicatedInputPinOne, generalInputPins};
      pinSync <= pinMeta;
    end
  end
  // A new level counts only after holding for the minimum pulse width.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinStable <= 5'h0;
      pinCand <= 5'h0;
      pinChanged <= 5'h0;
      for (int i = 0; i < 5; i++) begin
        pinCnt[i] <= 32'h0;
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        pinChanged[i] <= 1'b0;
        if (pinSync[i] != pinCand[i]) begin
          pinCand[i] <= pinSync[i];
          pinCnt[i] <= 32'h0;
        end else if (pinCand[i] != pinStable[i]) begin
          if (pinCnt[i] >= PULSE_CYCLES - 2) begin
            pinStable[i] <= pinCand[i];
            pinChanged[i] <= 1'b1;
          end else begin
            pinCnt[i] <= pinCnt[i] + 32'h1;
          end
        end
      end
    end
  end
  // ------------------------------------------------------------
  // Wake decision
  // ------------------------------------------------------------
  logic timerWake;  // Timer-driven cycling mode.
  logic pinWake;    // A qualified pin event this cycle.
  // Timer mode masks pin events, so a pin never cuts a timed sleep short.
  assign timerWake = IS_RECEIVER ? wakeSrcReg[`BIT_WAKE_ON_TIMER] : !modeReg[`BIT_TX_PIN_WAKE];
  assign pinWake = IS_RECEIVER
    ? (!wakeSrcReg[`BIT_WAKE_ON_TIMER] && |(pinChanged[3:0] & wakeSrcReg[3:0]))
    : (modeReg[`BIT_TX_PIN_WAKE] && pinChanged[4]);
  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  power_phase_t phaseReg;
  logic [23:0]  phaseCnt;   // Ticks left in the current phase.
  logic [23:0]  extWake;    // Extended wake length in ticks.
  logic         wakeArmed;  // Nonzero wake count enables both entry paths.
  assign wakeArmed = (wakeCountReg != 8'h00);
  // At most 256 * 255, so the 16-bit product never wraps.
  assign extWake = 24'((({8'h0, wakeExtReg} + 16'h1) * {8'h0, wakeCountReg}));
  // Phase transitions; timer expiry into sleep outranks relink attempts.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phaseReg <= PH_AWAKE;
      phaseCnt <= 24'h0;
    end else begin
      unique case (phaseReg)
        PH_AWAKE: begin
          if (pdBit && wakeArmed && (!IS_RECEIVER || rxSettingsApplied)) begin
            phaseReg <= PH_ASLEEP;
            phaseCnt <= {8'h0, sleepCountReg};
          end else if (!linkUp && wakeArmed) begin
            phaseReg <= PH_SEARCH;
            phaseCnt <= {8'h0, sleepCountReg};
          end
        end
        PH_SEARCH: begin
          if (linkUp) begin
            phaseReg <= PH_AWAKE;
          end else if (!wakeArmed) begin
            phaseReg <= PH_AWAKE;
          end else if (tick) begin
            if (phaseCnt <= 24'h1) begin
              phaseReg <= PH_ASLEEP;
              phaseCnt <= {8'h0, sleepCountReg};
            end else begin
              phaseCnt <= phaseCnt - 24'h1;
            end
          end
        end
        PH_ASLEEP: begin
          if (!timerWake && pinWake) begin
            phaseReg <= PH_RELINK;
            phaseCnt <= extWake;
          end else if (timerWake && tick) begin
            if (phaseCnt <= 24'h1) begin
              phaseReg <= PH_RELINK;
              phaseCnt <= {16'h0, wakeCountReg};
            end else begin
              phaseCnt <= phaseCnt - 24'h1;
            end
          end
        end
        PH_RELINK: begin
          if (linkUp && !pdBit) begin
            phaseReg <= PH_AWAKE;
          end else if (!wakeArmed) begin
            phaseReg <= PH_AWAKE;
          end else if (tick) begin
            if (phaseCnt <= 24'h1) begin
              phaseReg <= PH_ASLEEP;
              phaseCnt <= {8'h0, sleepCountReg};
            end else begin
              phaseCnt <= phaseCnt - 24'h1;
            end
          end
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic wakeFlag; // Live wake status, needs no clearing.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      powerDown <= 1'b0;
      wakeFlag <= 1'b0;
      irqOut <= 1'b1;
    end else begin
      powerDown <= (phaseReg == PH_ASLEEP);
      wakeFlag <= (phaseReg != PH_ASLEEP);
      // Polarity bit high means active high; only the wake source drives the pin.
      irqOut <= (intCfgReg[`BIT_INT_WAKE_ENABLE] && phaseReg != PH_ASLEEP)
                == intCfgReg[`BIT_INT_POLARITY];
    end
  end
  // Read mux, registered so read data comes from flip-flops.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= 8'h00;
      if (regRdAddr == `OFS_RX_WAKE_SOURCES) begin
        regRdData <= wakeSrcReg;
      end
      if (regRdAddr == ownSleepLo) begin
        regRdData <= sleepCountReg[7:0];
      end
      if (regRdAddr == ownSleepHi) begin
        regRdData <= sleepCountReg[15:8];
      end
      if (regRdAddr == ownWakeOfs) begin
        regRdData <= wakeCountReg;
      end
      if (regRdAddr == ownExtOfs) begin
        regRdData <= wakeExtReg;
      end
      if (regRdAddr == ownModeOfs) begin
        regRdData <= modeReg;
      end
      if (regRdAddr == `OFS_INT_CONFIG) begin
        regRdData <= intCfgReg;
      end
      if (regRdAddr == `OFS_RX_UPDATE) begin
        regRdData <= updateReg;
      end
      if (regRdAddr == `OFS_INT_FLAGS) begin
        regRdData <= {6'h0, wakeFlag, 1'b0};
      end
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_NO_SLEEP_ZERO_WAKE: assert property (@(posedge sys_clk) disable iff (rst)
    (phaseReg == PH_AWAKE && !wakeArmed) |=> phaseReg != PH_ASLEEP)
    else $error("Entered sleep with zero wake count.");
  AST_UPDATE_OUTCOME: assert property (@(posedge sys_clk) disable iff (rst)
    (updateReg == `UPDATE_BUSY && transferDone && !transferOk) |=> updateReg == `UPDATE_FAILED)
    else $error("Failed transfer not reported.");
  AST_UPDATE_START: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(transferStart) |-> updateReg == `UPDATE_BUSY)
    else $error("Transfer started without busy status.");
  AST_TIMER_BLOCKS_PIN: assert property (@(posedge sys_clk) disable iff (rst)
    (phaseReg == PH_ASLEEP && timerWake && !tick) |=> phaseReg == PH_ASLEEP)
    else $error("Timer mode woke without tick.");
  AST_PIN_WAKES: assert property (@(posedge sys_clk) disable iff (rst)
    (phaseReg == PH_ASLEEP && !timerWake && pinWake) |=> phaseReg == PH_RELINK ##1 !powerDown)
    else $error("Pin event did not wake.");
  AST_LINK_HOLDS: assert property (@(posedge sys_clk) disable iff (rst)
    (phaseReg == PH_RELINK && linkUp && !pdBit) |=> phaseReg == PH_AWAKE)
    else $error("Linked end did not stay awake.");
  AST_ZERO_WAKE_STAYS: assert property (@(posedge sys_clk) disable iff (rst)
    (phaseReg == PH_AWAKE && !wakeArmed) |=> phaseReg == PH_AWAKE)
    else $error("Zero wake count did not keep the end awake.");
  AST_IRQ_TRACKS: assert property (@(posedge sys_clk) disable iff (rst)
    (intCfgReg[`BIT_INT_WAKE_ENABLE] && !intCfgReg[`BIT_INT_POLARITY] && $stable(intCfgReg))
      |=> irqOut == ($past(phaseReg) == PH_ASLEEP))
    else $error("Interrupt pin does not follow sleep state.");
  AST_TICK_ONLY: assert property (@(posedge sys_clk) disable iff (rst)
    (phaseReg == PH_SEARCH && !tick && !linkUp && wakeArmed) |=> $stable(phaseCnt))
    else $error("Search counter moved without tick.");
  COV_AUTO_SLEEP: cover property (@(posedge sys_clk) disable iff (rst)
    phaseReg == PH_SEARCH ##1 phaseReg == PH_ASLEEP);
  COV_PIN_WAKE: cover property (@(posedge sys_clk) disable iff (rst)
    phaseReg == PH_ASLEEP ##1 phaseReg == PH_RELINK && !timerWake);
  COV_RESLEEP: cover property (@(posedge sys_clk) disable iff (rst)
    phaseReg == PH_RELINK ##1 phaseReg == PH_ASLEEP);
endmodule

// ### tb/mcu_link_partner.sv
// Model of the controlling microcontroller on the serial slave register port.
// Assumes the bench clock and that requests change at the falling clock edge.
`timescale 1ns/1ps
module mcu_link_partner
  import radio_power_pkg::*;
(
  input  wire logic       sys_clk,    // Bench clock.
  output reg_req_t        regReq,     // Write request towards the device.
  output logic [6:0]      regRdAddr,  // Read address towards the device.
  input  wire logic [7:0] regRdData   // Registered read data.
);
  // ----------------------------------------
  // Port idle state
  // ----------------------------------------
  // Nothing is requested before the first write.
  initial begin
    regReq = '0;
    regRdAddr = 7'h00;
  end

  // One write, held for one cycle.
  // Address and data are inverted after each write, so a stale value never looks valid.
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regReq = '{1'b1, a, d};
    @(negedge sys_clk);
    regReq = '{1'b0, ~a, ~d};
  endtask

  // The address stands for one cycle, then the registered data is taken.
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    regRdAddr = a;
    @(negedge sys_clk);
    d = regRdData;
  endtask

  // The receiver sleep bit and update request are written before the transmitter sleep bit; the receiver sleeps only on the later transfer answer.
  task automatic sleep_pair();
    write_reg(`OFS_RX_MODE, 8'h80);
    write_reg(`OFS_RX_UPDATE, 8'h01);
    write_reg(`OFS_TX_MODE, 8'h40);
  endtask

  // Once linked, both wake counts are cleared to stop automatic sleep.
  task automatic clear_wake_counts();
    write_reg(`OFS_RX_WAKE_COUNT, 8'h00);
    write_reg(`OFS_TX_WAKE_COUNT, 8'h00);
  endtask
endmodule

// ### tb/radio_power_down_wake_control_tb.sv
// Self-checking bench for both ends of the power-down and wake controller on one port.
// Assumes shortened tick and pin-filter counts, and a bench-driven link and transfer channel.
`timescale 1ns/1ps
`include "radio_power_defines.svh"
module radio_power_down_wake_control_tb;
  import radio_power_pkg::*;
  localparam int TK = 20; // Cycles per shortened tick.
  localparam int PW = 4;  // Cycles a wake pin must hold.
  logic       sysClk;               // 200 MHz clock.
  logic       rst;                  // Active-high reset.
  reg_req_t   regReq;               // Write request from the partner.
  logic [6:0] regRdAddr;            // Read address from the partner.
  logic [7:0] regRdData;            // Read data to the partner.
  logic       linkUp;               // Radio link present.
  logic       transferDone;         // Transfer finished pulse.
  logic       transferOk;           // Transfer outcome.
  logic       transferStart;        // Transfer request pulse.
  logic [3:0] generalInputPins;     // Receiver wake pins.
  logic       dedicatedInputPinOne; // Transmitter wake pin.
  logic       powerDown;            // Sleep output.
  logic       irqOut;               // Interrupt pin.
  logic       txPowerDown;          // Sleep output of the transmitter end.
  logic       selTx = 1'b0;         // Waits follow the transmitter end when set.
  logic [7:0] shadow [0:127];       // Expected register contents.
  logic [7:0] rdVal;                // Last value read.
  logic [31:0] seed = 32'h0000003A; // Random state, starts at 58.
  int         badCount;             // Mismatches seen.
  int         checksDone;           // Comparisons made.
  int         startCount;           // Transfer requests seen.
  int         cycleCount;           // Cycles since start.
  int         n;                    // Measured wait.
  logic [6:0] regList [6] = '{`OFS_RX_WAKE_SOURCES, `OFS_RX_SLEEP_LOW, `OFS_RX_SLEEP_HIGH,
                              `OFS_RX_WAKE_COUNT, `OFS_RX_WAKE_EXT, `OFS_INT_CONFIG};

  always #2.5 sysClk = ~sysClk;

  radio_power_down_wake_control #(.IS_RECEIVER(1'b1), .TICK_CYCLES(TK), .PULSE_CYCLES(PW))
    i_radio_power_down_wake_control (.sys_clk(sysClk), .rst(rst), .regReq(regReq),
    .regRdAddr(regRdAddr), .regRdData(regRdData), .linkUp(linkUp), .transferDone(transferDone),
    .transferOk(transferOk), .transferStart(transferStart), .generalInputPins(generalInputPins),
    .dedicatedInputPinOne(dedicatedInputPinOne), .powerDown(powerDown), .irqOut(irqOut));

  radio_power_down_wake_control #(.IS_RECEIVER(1'b0), .TICK_CYCLES(TK), .PULSE_CYCLES(PW))
    i_radio_power_down_wake_control_tx (.sys_clk(sysClk), .rst(rst), .regReq(regReq), .regRdAddr(regRdAddr),
    .regRdData(), .linkUp(linkUp), .transferDone(transferDone), .transferOk(transferOk), .transferStart(),
    .generalInputPins(generalInputPins), .dedicatedInputPinOne(dedicatedInputPinOne),
    .powerDown(txPowerDown), .irqOut());

  mcu_link_partner i_mcu_link_partner (.sys_clk(sysClk), .regReq(regReq), .regRdAddr(regRdAddr),
    .regRdData(regRdData));

  // ----------------------------------------
  // Monitors and hang guard
  // ----------------------------------------
  // A limit far above the run length, so only a hang reaches it.
  always @(posedge sysClk) begin
    cycleCount <= cycleCount + 1;
    if (transferStart === 1'b1) begin
      startCount <= startCount + 1;
    end
    if (cycleCount == 20000) begin
      badCount++;
      complete_run();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Xorshift source for register data.
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // Compares one byte result.
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compares one pin or flag result.
  task automatic check_bit(input logic got, input logic exp);
    check_byte({7'h00, got}, {7'h00, exp});
  endtask

  // A measured wait must fall inside the window.
  task automatic in_range(input int v, input int lo, input int hi);
    check_bit(v >= lo && v <= hi, 1'b1);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_mcu_link_partner.write_reg(a, d);
    shadow[a] = (a == `OFS_RX_WAKE_SOURCES) ? (d & 8'h1F) : d;
  endtask

  task automatic rd_exp(input logic [6:0] a, input logic [7:0] e);
    i_mcu_link_partner.read_reg(a, rdVal);
    check_byte(rdVal, e);
  endtask

  // Bounded wait for the sleep output to reach a level; counts cycles.
  task automatic wait_pd(input logic lvl, input int mx, output int c);
    c = 0;
    while ((selTx ? txPowerDown : powerDown) !== lvl && c < mx) begin
      @(negedge sysClk);
      c++;
    end
  endtask

  // One answer from the control channel.
  task automatic pulse_done(input logic ok);
    @(negedge sysClk);
    transferDone = 1'b1;
    transferOk = ok;
    @(negedge sysClk);
    transferDone = 1'b0;
    transferOk = ~ok;
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sysClk = 1'b0;
    rst = 1'b1;
    linkUp = 1'b1;
    transferDone = 1'b0;
    transferOk = 1'b0;
    generalInputPins = 4'h0;
    dedicatedInputPinOne = 1'b0;
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (3) @(posedge sysClk);
    @(negedge sysClk);
    rst = 1'b0;
    // Reset values, random write and read back, and an unmapped place.
    foreach (regList[i]) rd_exp(regList[i], shadow[regList[i]]);
    rd_exp(`OFS_RX_MODE, 8'h00);
    foreach (regList[i]) begin
      wr(regList[i], rnd());
      rd_exp(regList[i], shadow[regList[i]]);
    end
    i_mcu_link_partner.write_reg(7'h10, rnd());
    rd_exp(7'h10, 8'h00);
    $display("test registers done");
    // Update status and refusal with a zero wake count.
    wr(`OFS_RX_WAKE_COUNT, 8'h00);
    wr(`OFS_RX_MODE, 8'h80);
    wr(`OFS_RX_UPDATE, 8'h01);
    rd_exp(`OFS_RX_UPDATE, `UPDATE_BUSY);
    check_bit(startCount == 1, 1'b1);
    pulse_done(1'b0);
    rd_exp(`OFS_RX_UPDATE, `UPDATE_FAILED);
    wr(`OFS_RX_UPDATE, 8'h01);
    pulse_done(1'b1);
    rd_exp(`OFS_RX_UPDATE, `UPDATE_IDLE_OK);
    repeat (5) @(negedge sysClk);
    check_bit(powerDown, 1'b0);
    $display("test update done");
    // Link loss with pin wake configured.
    wr(`OFS_RX_MODE, 8'h00);
    wr(`OFS_RX_WAKE_SOURCES, 8'h01);
    wr(`OFS_RX_SLEEP_LOW, 8'h03);
    wr(`OFS_RX_SLEEP_HIGH, 8'h00);
    wr(`OFS_RX_WAKE_COUNT, 8'h02);
    wr(`OFS_RX_WAKE_EXT, 8'h01);
    wr(`OFS_INT_CONFIG, 8'h02);
    linkUp = 1'b0;
    wait_pd(1'b1, 6 * TK, n);
    in_range(n, 2 * TK, 4 * TK + 4);
    repeat (10 * TK) @(negedge sysClk);
    check_bit(powerDown, 1'b1);
    check_bit(irqOut, 1'b1);
    generalInputPins[1] = 1'b1;
    repeat (2 * TK) @(negedge sysClk);
    check_bit(powerDown, 1'b1);
    generalInputPins[0] = 1'b1;
    repeat (2) @(negedge sysClk);
    generalInputPins[0] = 1'b0;
    repeat (TK) @(negedge sysClk);
    check_bit(powerDown, 1'b1);
    generalInputPins[0] = 1'b1;
    wait_pd(1'b0, PW + 8, n);
    in_range(n, PW - 1, PW + 7);
    repeat (2) @(negedge sysClk);
    check_bit(irqOut, 1'b0);
    rd_exp(`OFS_INT_FLAGS, 8'h02);
    wait_pd(1'b1, 8 * TK, n);
    in_range(n, 3 * TK - PW, 5 * TK + 4);
    $display("test pin wake done");
    // Relink with the sleep bit clear, then no automatic sleep.
    generalInputPins[0] = 1'b0;
    wait_pd(1'b0, PW + 8, n);
    linkUp = 1'b1;
    repeat (10 * TK) @(negedge sysClk);
    check_bit(powerDown, 1'b0);
    i_mcu_link_partner.clear_wake_counts();
    shadow[`OFS_RX_WAKE_COUNT] = 8'h00;
    linkUp = 1'b0;
    repeat (10 * TK) @(negedge sysClk);
    check_bit(powerDown, 1'b0);
    linkUp = 1'b1;
    $display("test relink done");
    // Timer wake has priority over pins.
    wr(`OFS_RX_WAKE_SOURCES, 8'h11);
    wr(`OFS_RX_SLEEP_LOW, 8'h04);
    wr(`OFS_RX_WAKE_COUNT, 8'h02);
    wr(`OFS_INT_CONFIG, 8'h82);
    i_mcu_link_partner.sleep_pair();
    pulse_done(1'b1);
    wait_pd(1'b1, 4, n);
    in_range(n, 0, 3);
    generalInputPins[0] = 1'b1;
    repeat (2) @(negedge sysClk);
    check_bit(irqOut, 1'b0);
    wait_pd(1'b0, 7 * TK, n);
    in_range(n, 3 * TK - 2, 5 * TK + 4);
    repeat (2) @(negedge sysClk);
    check_bit(irqOut, 1'b1);
    wait_pd(1'b1, 4 * TK, n);
    in_range(n, TK - 4, 3 * TK + 4);
    $display("test timer wake done");
    // Transmitter end: held awake by a zero wake count, then woken by its own pin.
    selTx = 1'b1;
    check_bit(txPowerDown, 1'b0);
    wr(`OFS_TX_SLEEP_HIGH, 8'h40);
    wr(`OFS_TX_WAKE_COUNT, 8'h02);
    wait_pd(1'b1, 4, n);
    in_range(n, 0, 3);
    wr(`OFS_TX_MODE, 8'h20);
    linkUp = 1'b0;
    dedicatedInputPinOne = 1'b1;
    wait_pd(1'b0, PW + 8, n);
    in_range(n, PW - 1, PW + 7);
    wait_pd(1'b1, 3 * TK, n);
    in_range(n, TK - 2, 2 * TK + 4);
    $display("test transmitter done");
    complete_run();
  end
endmodule
